// ==== rtl/adcsci_pkg.sv ====
// package: constants for the adc serial command interface
`default_nettype none
package adcsci_pkg;
  localparam int CMD_W = 8;
  localparam int RES_W = 14;
  localparam logic [7:0] CMD_RESET = 8'h06;
  localparam int CH_HI = 7;
  localparam int CH_LO = 5;
  localparam int SCAN_HI = 4;
  localparam int SCAN_LO = 3;
  localparam int PD_HI = 2;
  localparam int PD_LO = 1;
  localparam int CLKSRC_BIT = 0;
  localparam logic [1:0] PD_ALL_ON = 2'h0;
  localparam logic [1:0] PD_ALL_OFF = 2'h1;
  localparam logic [1:0] PD_BUF_OFF = 2'h2;
  localparam logic [1:0] PD_EXT_REF = 2'h3;
  localparam logic [1:0] SCAN_NONE = 2'h0;
  localparam logic [1:0] SCAN_FROM0 = 2'h1;
  localparam logic [1:0] SCAN_FROMMID = 2'h2;
  localparam logic [1:0] SCAN_REPEAT = 2'h3;
  localparam logic [4:0] EDGE_CHSEL = 5'h03;
  localparam logic [4:0] EDGE_SAMPLE = 5'h06;
  localparam logic [4:0] EDGE_CMD_DONE = 5'h08;
  localparam logic [4:0] EDGE_RES_END = 5'h18;
  localparam logic [4:0] EDGE_MAX = 5'h1F;
  localparam int REF_WAKE_MS = 5;
  localparam int CLK_MHZ = 100;
  localparam int REF_WAKE_CYC = REF_WAKE_MS * 1000 * CLK_MHZ;
  typedef enum logic [3:0] {
    ADCSCI_IDLE = 4'b0001,
    ADCSCI_CMD = 4'b0010,
    ADCSCI_CONV = 4'b0100,
    ADCSCI_TAIL = 4'b1000
  } adcsci_state_t;
endpackage
`default_nettype wire

// ==== rtl/adcsci_if.sv ====
// interface: pin-side edge events between synchroniser and core
`default_nettype none
interface adcsci_if;
  logic csn_lvl;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic din_lvl;
  logic fsr_fall;
  modport src (output csn_lvl, cs_fall, cs_rise, sclk_rise, sclk_fall, din_lvl, fsr_fall);
  modport dst (input csn_lvl, cs_fall, cs_rise, sclk_rise, sclk_fall, din_lvl, fsr_fall);
endinterface
`default_nettype wire

// ==== rtl/adcsci_sync.sv ====
// module: two-stage pin synchronisers and edge detection
`default_nettype none
module adcsci_sync (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic csn_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic fsr_i,
  adcsci_if.src ev
);
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  // first stage read only by second stage
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // idle pin levels: select and frame-sync high, sclk low, so no false edge
      s1_ff <= 4'h9;
      s2_ff <= 4'h9;
      s3_ff <= 4'h9;
    end else begin
      s1_ff <= {fsr_i, din_i, sclk_i, csn_i};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  assign ev.csn_lvl = s2_ff[0];
  assign ev.cs_fall = s3_ff[0] & ~s2_ff[0];
  assign ev.cs_rise = ~s3_ff[0] & s2_ff[0];
  assign ev.sclk_rise = ~s3_ff[1] & s2_ff[1];
  assign ev.sclk_fall = s3_ff[1] & ~s2_ff[1];
  assign ev.din_lvl = s2_ff[2];
  assign ev.fsr_fall = s3_ff[3] & ~s2_ff[3];
endmodule
`default_nettype wire

// ==== rtl/adcsci_top.sv ====
// top: serial command register, power-down control and result shifter
`default_nettype none
module adcsci_top #(
  parameter int NUM_CH = 8,
  parameter int REF_WAKE = adcsci_pkg::REF_WAKE_CYC
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic csn_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic frame_sync_receive_in_i,
  input wire logic transfer_width_select_i,
  input wire logic dsp_mode_i,
  input wire logic [13:0] conv_result_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic frame_sync_transmit_out_o,
  output logic [2:0] analog_input_n_o,
  output logic [1:0] scan_mode_o,
  output logic clock_source_select_o,
  output logic reference_on_o,
  output logic buffer_on_o,
  output logic ref_ready_o,
  output logic acquire_o,
  output logic sample_o,
  output logic converting_o,
  output logic shutdown_o,
  output logic [7:0] cmd_o
);
  adcsci_if ev ();
  adcsci_sync u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .csn_i(csn_i),
    .sclk_i(sclk_i),
    .din_i(din_i),
    .fsr_i(frame_sync_receive_in_i),
    .ev(ev)
  );

  // ========================================
  // registers
  adcsci_pkg::adcsci_state_t state_ff, nxt_state;
  logic [7:0] cmd_ff;
  logic [7:0] shift_ff;
  logic [4:0] rise_cnt_ff;
  logic [4:0] fall_cnt_ff;
  logic [15:0] res_ff;
  logic dout_ff;
  logic oe_ff;
  logic [2:0] chan_ff;
  logic acq_ff;
  logic conv_ff;
  logic sample_ff;
  logic ref_on_ff;
  logic buf_on_ff;
  logic [31:0] wake_cnt_ff;
  logic fs_tx_ff;
  // first fall count whose shifted bit lies past the result
  localparam logic [4:0] ZERO_FROM = adcsci_pkg::EDGE_CMD_DONE + 5'(adcsci_pkg::RES_W) - 5'h01;

  // ========================================
  // decode
  wire [1:0] pd_sel = cmd_ff[adcsci_pkg::PD_HI:adcsci_pkg::PD_LO];
  wire cmd_last = ev.sclk_rise && (rise_cnt_ff == adcsci_pkg::EDGE_CMD_DONE - 5'h01);
  wire [7:0] cmd_new = {shift_ff[6:0], ev.din_lvl};
  wire chsel_edge = ev.sclk_rise && (rise_cnt_ff == adcsci_pkg::EDGE_CHSEL - 5'h01);
  wire [2:0] chsel_val = {shift_ff[1:0], ev.din_lvl};
  // four-channel variant keeps two channel bits
  wire [2:0] ch_mask = (NUM_CH > 4) ? 3'h7 : 3'h3;
  wire sample_edge = ev.sclk_fall && (fall_cnt_ff == adcsci_pkg::EDGE_SAMPLE - 5'h01);
  wire msb_edge = ev.sclk_fall && (fall_cnt_ff == adcsci_pkg::EDGE_CMD_DONE - 5'h01);
  wire active = !ev.csn_lvl;
  wire wake_src = dsp_mode_i ? ev.fsr_fall : ev.cs_fall;
  wire full_off = (pd_sel == adcsci_pkg::PD_ALL_OFF);
  wire ext_ref = (pd_sel == adcsci_pkg::PD_EXT_REF);

  // ========================================
  // state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      adcsci_pkg::ADCSCI_IDLE: if (ev.cs_fall) nxt_state = adcsci_pkg::ADCSCI_CMD;
      adcsci_pkg::ADCSCI_CMD: begin
        if (ev.cs_rise) nxt_state = adcsci_pkg::ADCSCI_IDLE;
        else if (sample_edge) nxt_state = adcsci_pkg::ADCSCI_CONV;
      end
      adcsci_pkg::ADCSCI_CONV: begin
        if (ev.cs_rise) nxt_state = adcsci_pkg::ADCSCI_IDLE;
        else if (ev.sclk_fall && fall_cnt_ff == adcsci_pkg::EDGE_RES_END - 5'h01)
          nxt_state = adcsci_pkg::ADCSCI_TAIL;
      end
      // tail only marks result done; zeros come from the drained shifter
      adcsci_pkg::ADCSCI_TAIL: if (ev.cs_rise) nxt_state = adcsci_pkg::ADCSCI_IDLE;
      default: nxt_state = adcsci_pkg::ADCSCI_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) state_ff <= adcsci_pkg::ADCSCI_IDLE;
    else state_ff <= nxt_state;
  end

  // ========================================
  // edge counters, saturating
  // saturate so a runaway sclk cannot wrap back onto edges 3, 6 or 8
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rise_cnt_ff <= 5'h00;
      fall_cnt_ff <= 5'h00;
    end else if (ev.cs_fall || !active) begin
      rise_cnt_ff <= 5'h00;
      fall_cnt_ff <= 5'h00;
    end else begin
      if (ev.sclk_rise && rise_cnt_ff != adcsci_pkg::EDGE_MAX) rise_cnt_ff <= rise_cnt_ff + 5'h01;
      if (ev.sclk_fall && fall_cnt_ff != adcsci_pkg::EDGE_MAX) fall_cnt_ff <= fall_cnt_ff + 5'h01;
    end
  end

  // ========================================
  // command register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_ff <= 8'h00;
      cmd_ff <= adcsci_pkg::CMD_RESET;
    end else if (active) begin
      // shifter freezes after 8 rises so late rises cannot disturb it
      // sample din on rising sclk
      if (ev.sclk_rise && rise_cnt_ff < adcsci_pkg::EDGE_CMD_DONE) shift_ff <= cmd_new;
      // commit only on 8th rising edge
      if (cmd_last) cmd_ff <= cmd_new;
    end
  end

  // ========================================
  // acquisition and conversion markers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan_ff <= 3'h0;
      acq_ff <= 1'b0;
      conv_ff <= 1'b0;
      sample_ff <= 1'b0;
    end else begin
      sample_ff <= 1'b0;
      if (!active) begin
        acq_ff <= 1'b0;
        conv_ff <= 1'b0;
      end else if (chsel_edge) begin
        // channel chosen on 3rd rising edge, acquisition begins
        chan_ff <= chsel_val & ch_mask;
        acq_ff <= 1'b1;
      end else if (sample_edge) begin
        acq_ff <= 1'b0;
        conv_ff <= 1'b1;
        sample_ff <= 1'b1;
      end else if (msb_edge) begin
        conv_ff <= 1'b0;
      end
    end
  end

  // ========================================
  // result shifter and data output
  // result must already be stable at the 8th fall; it is not held earlier
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_ff <= 16'h0000;
      dout_ff <= 1'b0;
      oe_ff <= 1'b0;
      fs_tx_ff <= 1'b0;
    end else begin
      fs_tx_ff <= 1'b0;
      if (!active) begin
        oe_ff <= 1'b0;
        dout_ff <= 1'b0;
      end else if (ev.cs_fall) begin
        oe_ff <= 1'b1;
        dout_ff <= 1'b0;
      end else if (msb_edge) begin
        // msb first, 14 bits then zeros
        dout_ff <= conv_result_i[adcsci_pkg::RES_W-1];
        // 13 bits left plus three zeros fill the 16-bit shifter
        res_ff <= {conv_result_i[adcsci_pkg::RES_W-2:0], 3'h0};
        fs_tx_ff <= dsp_mode_i;
      end else if (ev.sclk_fall && fall_cnt_ff >= adcsci_pkg::EDGE_CMD_DONE) begin
        dout_ff <= res_ff[15];
        res_ff <= {res_ff[14:0], 1'b0};
      end
    end
  end

  // ========================================
  // reference and buffer power
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_on_ff <= 1'b0;
      buf_on_ff <= 1'b0;
      wake_cnt_ff <= 32'h0000_0000;
    end else begin
      if (ev.cs_rise) begin
        // enter selected mode on chip select rise
        ref_on_ff <= (pd_sel == adcsci_pkg::PD_ALL_ON) || (pd_sel == adcsci_pkg::PD_BUF_OFF);
        buf_on_ff <= (pd_sel == adcsci_pkg::PD_ALL_ON);
      end else if (wake_src && !ext_ref) begin
        // wake buffer on select or frame-sync fall
        if (!ref_on_ff && full_off) wake_cnt_ff <= REF_WAKE[31:0];
        ref_on_ff <= 1'b1;
        buf_on_ff <= 1'b1;
      end else if (wake_cnt_ff != 32'h0000_0000) begin
        wake_cnt_ff <= wake_cnt_ff - 32'h0000_0001;
      end
    end
  end

  // ========================================
  // outputs
  assign dout_o = dout_ff;
  assign dout_oe_o = oe_ff;
  assign frame_sync_transmit_out_o = fs_tx_ff;
  assign analog_input_n_o = chan_ff;
  // scan field passed to the sequencer
  assign scan_mode_o = cmd_ff[adcsci_pkg::SCAN_HI:adcsci_pkg::SCAN_LO];
  assign clock_source_select_o = cmd_ff[adcsci_pkg::CLKSRC_BIT];
  assign reference_on_o = ref_on_ff;
  assign buffer_on_o = buf_on_ff;
  // status only; host owns the wait
  assign ref_ready_o = (wake_cnt_ff == 32'h0000_0000);
  assign acquire_o = acq_ff;
  assign sample_o = sample_ff;
  assign converting_o = conv_ff;
  // lags the pin by the two synchroniser stages
  assign shutdown_o = ev.csn_lvl;
  // command view; width select is not used, only the 8-bit path exists here
  assign cmd_o = cmd_ff;

  // ========================================
  // checks
  a_cmd_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !cmd_last |=> $stable(cmd_ff)) else $error("command changed off 8th edge");
  a_cmd_load: assert property (@(posedge clock_i) disable iff (!nrst_i)
    cmd_last && active |=> cmd_ff == $past(cmd_new)) else $error("command not loaded");
  a_hiz_idle: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ev.csn_lvl |=> !dout_oe_o) else $error("dout driven with cs high");
  a_low_start: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ev.cs_fall |=> dout_oe_o && !dout_o) else $error("dout not low after cs fall");
  a_chan_pick: assert property (@(posedge clock_i) disable iff (!nrst_i)
    chsel_edge && active |=> acquire_o && analog_input_n_o == $past(chsel_val & ch_mask))
    else $error("channel not selected");
  a_sample_at: assert property (@(posedge clock_i) disable iff (!nrst_i)
    sample_edge && active && !chsel_edge |=> sample_o && converting_o)
    else $error("sample missing");
  a_tail_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
    state_ff == adcsci_pkg::ADCSCI_TAIL && ev.sclk_fall && active |=> !dout_o)
    else $error("tail not zero");
  a_abort_conv: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ev.cs_rise |=> state_ff == adcsci_pkg::ADCSCI_IDLE && !converting_o)
    else $error("abort failed");
  a_pd_enter: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ev.cs_rise && pd_sel == adcsci_pkg::PD_EXT_REF |=> !reference_on_o && !buffer_on_o)
    else $error("power-down not entered");

  // ========================================
  // command shift, acquisition, result and power checks
  a_din_shift: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ev.sclk_rise && active && rise_cnt_ff < adcsci_pkg::EDGE_CMD_DONE |=>
    shift_ff[0] == $past(ev.din_lvl)) else $error("din not shifted on rise");
  a_acq_end: assert property (@(posedge clock_i) disable iff (!nrst_i)
    sample_edge && active |=> !acquire_o)
    else $error("acquisition not ended at sample");
  a_msb_first: assert property (@(posedge clock_i) disable iff (!nrst_i)
    msb_edge && active |=> dout_o == $past(conv_result_i[adcsci_pkg::RES_W-1]))
    else $error("msb not placed on 8th fall");
  a_conv_stop: assert property (@(posedge clock_i) disable iff (!nrst_i)
    msb_edge && active |=> !converting_o)
    else $error("conversion still running at msb");
  a_res_zeros: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ev.sclk_fall && active && fall_cnt_ff >= ZERO_FROM |=> !dout_o)
    else $error("result tail not zero");
  a_fs_pulse: assert property (@(posedge clock_i) disable iff (!nrst_i)
    msb_edge && active && dsp_mode_i |=> frame_sync_transmit_out_o)
    else $error("frame pulse missing at msb");
  a_pd_all_on: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ev.cs_rise && pd_sel == adcsci_pkg::PD_ALL_ON |=> reference_on_o && buffer_on_o)
    else $error("reference or buffer off in all-on mode");
  a_pd_full_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ev.cs_rise && pd_sel == adcsci_pkg::PD_ALL_OFF |=> !reference_on_o && !buffer_on_o)
    else $error("full power-down not entered");
  a_pd_buf_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ev.cs_rise && pd_sel == adcsci_pkg::PD_BUF_OFF |=> reference_on_o && !buffer_on_o)
    else $error("buffer-off mode not entered");
  a_buf_wake: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wake_src && !ext_ref && !ev.cs_rise |=> reference_on_o && buffer_on_o)
    else $error("buffer did not wake");
  a_ext_stays: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ext_ref && !buffer_on_o && !ev.cs_rise |=> !buffer_on_o)
    else $error("buffer woke in external reference mode");
  a_ref_wait: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wake_src && !ext_ref && full_off && !reference_on_o && !ev.cs_rise |=> !ref_ready_o)
    else $error("settle timer not started");
  c_full_frame: cover property (@(posedge clock_i) disable iff (!nrst_i)
    state_ff == adcsci_pkg::ADCSCI_TAIL ##1 ev.cs_rise);
  c_abort: cover property (@(posedge clock_i) disable iff (!nrst_i)
    state_ff == adcsci_pkg::ADCSCI_CONV && ev.cs_rise);
  c_cut_cmd: cover property (@(posedge clock_i) disable iff (!nrst_i)
    state_ff == adcsci_pkg::ADCSCI_CMD && ev.cs_rise);
  c_ref_wake: cover property (@(posedge clock_i) disable iff (!nrst_i)
    wake_src && full_off && !reference_on_o);
  c_frame_wake: cover property (@(posedge clock_i) disable iff (!nrst_i)
    dsp_mode_i && ev.fsr_fall);
endmodule
`default_nettype wire

// ==== verif/adcsci_host_model.sv ====
// host model: serial controller framing command and readout transfers
`default_nettype none
module adcsci_host_model (
  input wire logic clock_i,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  input wire logic ref_ready_i,
  output logic csn_o,
  output logic sclk_o,
  output logic din_o,
  output logic oe_bad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    csn_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
    oe_bad_o = 1'b0;
  end
  // ==========================================
  // framing tasks
  task automatic open();
    @(negedge clock_i);
    csn_o = 1'b0;
    repeat (6) @(negedge clock_i);
  endtask
  // sclk stands low outside frames; din released shows inverse of last bit
  task automatic xfer(input logic [7:0] cmd, input int nclk, output logic [31:0] rx);
    rx = 32'h0;
    if (csn_o) open();
    for (int w = 0; w < 200 && ref_ready_i !== 1'b1; w++) @(negedge clock_i);
    for (int i = 0; i < nclk; i++) begin
      din_o = (i < 8) ? cmd[7 - i] : 1'b0;
      repeat (8) @(negedge clock_i);
      rx[31 - i] = dout_i;
      if (dout_oe_i !== 1'b1) oe_bad_o = 1'b1;
      sclk_o = 1'b1;
      repeat (8) @(negedge clock_i);
      sclk_o = 1'b0;
    end
    repeat (8) @(negedge clock_i);
    csn_o = 1'b1;
    din_o = ~din_o;
    // keep select high for a minimum time before the next frame
    repeat (4) @(negedge clock_i);
  endtask
endmodule
`default_nettype wire

// ==== verif/adcsci_tb_top.sv ====
// testbench: readout, power-down, abort and frame-sync wake scenarios
`default_nettype none
module adcsci_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic csn_i, sclk_i, din_i, oe_bad;
  logic frame_sync_receive_in_i = 1'b1;
  logic transfer_width_select_i = 1'b0;
  logic dsp_mode_i = 1'b0;
  logic [13:0] conv_result_i = 14'h0000;
  logic dout_o, dout_oe_o, frame_sync_transmit_out_o, clock_source_select_o;
  logic reference_on_o, buffer_on_o, ref_ready_o, acquire_o, sample_o;
  logic converting_o, shutdown_o, sclk_q;
  logic [2:0] analog_input_n_o;
  logic [1:0] scan_mode_o;
  logic [7:0] cmd_o;
  logic [31:0] rx;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  int rises = 0;
  int acq_at = -1;
  int samp_at = -1;
  int fs_pulses = 0;
  logic csn_q = 1'b1;
  logic conv_at_rise = 1'b0;
  // ==========================================
  // design and host
  adcsci_top #(.NUM_CH(8), .REF_WAKE(20)) u_dut (.clock_i, .nrst_i, .csn_i, .sclk_i,
    .din_i, .frame_sync_receive_in_i, .transfer_width_select_i, .dsp_mode_i,
    .conv_result_i, .dout_o, .dout_oe_o, .frame_sync_transmit_out_o, .analog_input_n_o,
    .scan_mode_o, .clock_source_select_o, .reference_on_o, .buffer_on_o, .ref_ready_o,
    .acquire_o, .sample_o, .converting_o, .shutdown_o, .cmd_o);
  adcsci_host_model u_host (.clock_i(clock_i), .dout_i(dout_o), .dout_oe_i(dout_oe_o),
    .ref_ready_i(ref_ready_o), .csn_o(csn_i), .sclk_o(sclk_i), .din_o(din_i),
    .oe_bad_o(oe_bad));
  always #5 clock_i = ~clock_i;
  // ==========================================
  // monitor and timeout
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    sclk_q <= sclk_i;
    csn_q <= csn_i;
    if (csn_i && !csn_q) conv_at_rise <= converting_o;
    if (frame_sync_transmit_out_o === 1'b1) fs_pulses <= fs_pulses + 1;
    if (csn_i) rises <= 0;
    else if (sclk_i && !sclk_q) rises <= rises + 1;
    if (acquire_o === 1'b1 && acq_at < 0) acq_at <= rises;
    if (sample_o === 1'b1 && samp_at < 0) samp_at <= rises;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end
  task automatic check(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic results();
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    check(cmd_o === 8'h06, "power-on command");
    check(dout_oe_o === 1'b0 && shutdown_o === 1'b1, "idle shutdown");
  endtask
  // every channel code, result readout, extra pulses give zeros
  task automatic t_readout();
    for (int ch = 0; ch < 8; ch++) begin
      conv_result_i = {ch[2:0], 11'h4C5} ^ 14'h1001;
      acq_at = -1;
      samp_at = -1;
      u_host.xfer({ch[2:0], 5'h00}, 24 + ch % 3, rx);
      check(rx === {8'h00, conv_result_i, 10'h000}, "readout bits");
      check(rx[9:8] === 2'h0, "two zero clocks");
      check(oe_bad === 1'b0, "dout not driven in frame");
      check(cmd_o === {ch[2:0], 5'h00}, "stored command");
      check(analog_input_n_o === ch[2:0], "channel");
      check(clock_source_select_o === 1'b0 && scan_mode_o === 2'h0, "fields");
      check(acq_at == 3, "acquire edge");
      check(samp_at == 6, "sample edge");
      repeat (6) @(negedge clock_i);
      check(dout_oe_o === 1'b0 && shutdown_o === 1'b1, "released at cs high");
    end
    check(fs_pulses == 0, "frame pulse outside frame mode");
  endtask
  // each power-down code, then wake on chip select fall, except with external reference where buffer stays off
  task automatic t_power();
    logic [3:0] exp_ref, exp_buf;
    exp_ref = 4'h5;
    exp_buf = 4'h1;
    for (int pd = 0; pd < 4; pd++) begin
      u_host.xfer({5'h08, pd[1:0], 1'b0}, 24, rx);
      repeat (6) @(negedge clock_i);
      check(reference_on_o === exp_ref[pd] && buffer_on_o === exp_buf[pd], "pd");
      u_host.open();
      check(buffer_on_o === (pd != 3), "buffer wake");
      if (pd == 1) check(ref_ready_o === 1'b0, "settle pending");
      repeat (30) @(negedge clock_i);
      check(ref_ready_o === 1'b1, "settle done");
    end
  endtask
  // short frame: command discarded, conversion aborted
  task automatic t_abort();
    // one command sets scan field to 1 and the clock source bit
    u_host.xfer(8'hA9, 24, rx);
    check(scan_mode_o === 2'h1 && clock_source_select_o === 1'b1, "fields");
    u_host.xfer(8'hE0, 7, rx);
    repeat (6) @(negedge clock_i);
    check(cmd_o === 8'hA9, "short command kept old");
    check(conv_at_rise === 1'b1, "converting when select rose");
    check(converting_o === 1'b0 && shutdown_o === 1'b1, "abort");
  endtask
  // frame mode: frame-sync fall wakes the buffer
  task automatic t_frame();
    dsp_mode_i = 1'b1;
    u_host.xfer(8'h02, 24, rx);
    check(fs_pulses == 1, "one frame pulse at msb");
    repeat (6) @(negedge clock_i);
    check(buffer_on_o === 1'b0, "buffer off");
    frame_sync_receive_in_i = 1'b0;
    repeat (6) @(negedge clock_i);
    check(buffer_on_o === 1'b1, "frame wake");
    frame_sync_receive_in_i = 1'b1;
    dsp_mode_i = 1'b0;
  endtask
  initial begin
    repeat (10) @(negedge clock_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clock_i);
    t_reset();
    t_readout();
    t_power();
    t_abort();
    t_frame();
    results();
  end
endmodule
`default_nettype wire
